// ---- verilog/tcs_pkg.sv ----
// tcs_pkg: shared constants and carrier types for the channel status block
// assumes a 32-bit AXI4-Lite register bus and a four-slot destination queue
package tcs_pkg;

  // register map (byte addresses)
  localparam logic [11:0] TCS_CHANNEL_STATUS_OFS = 12'h100;

  // channel status field positions
  localparam int TCS_HEAD_OFS_LSB    = 11;
  localparam int TCS_HEAD_OFS_MSB    = 12;
  localparam int TCS_ONE_BIT         = 8;
  localparam int TCS_COUNT_LSB       = 4;
  localparam int TCS_COUNT_MSB       = 6;
  localparam int TCS_WR_PEND_BIT     = 2;
  localparam int TCS_SRC_ACTIVE_BIT  = 1;
  localparam int TCS_PROG_BUSY_BIT   = 0;

  // reset and fixed values
  localparam logic [31:0] TCS_STATUS_RESERVED = 32'h0000_0000;
  localparam logic        TCS_ONE_VALUE       = 1'b1;
  localparam logic [31:0] TCS_UNMAPPED_DATA   = 32'h0000_0000;

  // queue geometry and write counter width
  localparam int TCS_DEST_QUEUE_DEPTH = 4;
  localparam int TCS_COUNT_W          = 3;
  localparam int TCS_PTR_W            = 2;
  localparam int TCS_WR_CNT_W         = 4;

  // bus responses
  localparam logic [1:0] TCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TCS_RESP_SLVERR = 2'h2;

  // one queued move order as it travels from slot to source side and destination queue
  typedef struct packed {
    logic [7:0]  tag;
    logic [31:0] word;
  } tcs_order_s;

endpackage : tcs_pkg

// ---- verilog/tcs_dest_queue.sv ----
// tcs_dest_queue: flip-flop queue holding move orders for the destination side
// assumes the caller never pushes while full nor pops while empty
`timescale 1ns/1ps

module tcs_dest_queue
  import tcs_pkg::*;
#(
  parameter int DEPTH = TCS_DEST_QUEUE_DEPTH
)
(
  input  wire logic                   i_sys_clk,    // system clock
  input  wire logic                   i_nrst,       // async reset, active low
  input  wire logic                   i_push,       // write one order
  input  wire tcs_order_s             i_push_order, // order written
  input  wire logic                   i_pop,        // head order finished
  output tcs_order_s                  o_head,       // head order
  output logic [TCS_COUNT_W-1:0]      o_count,      // orders held
  output logic [TCS_PTR_W-1:0]        o_head_ptr,   // head slot offset
  output logic                        o_full,       // no free slot
  output logic                        o_empty       // nothing held
);

  // the count field and pointer widths only serve a four-slot queue
  if (DEPTH != (1 << TCS_PTR_W))
  begin : g_bad_depth
    $error("tcs_dest_queue: DEPTH must equal 2**TCS_PTR_W");
  end

  tcs_order_s                 mem_q [DEPTH];
  logic [TCS_PTR_W-1:0]       rd_q;
  logic [TCS_PTR_W-1:0]       wr_q;
  logic [TCS_COUNT_W-1:0]     cnt_q;

  // storage, one slot per entry
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_slot
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
      if (!i_nrst)
        mem_q[g] <= '0;
      else if (i_push && (wr_q == TCS_PTR_W'(g)))
        mem_q[g] <= i_push_order;
    end
  end

  // pointers wrap naturally at the power-of-two depth
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_q <= '0;
      wr_q <= '0;
    end
    else
    begin
      if (i_push)
        wr_q <= wr_q + 1'b1;
      if (i_pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // occupancy, never beyond DEPTH so codes above four never appear
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_q <= '0;
    else if (i_push && !i_pop)
      cnt_q <= cnt_q + 1'b1;
    else if (i_pop && !i_push)
      cnt_q <= cnt_q - 1'b1;
  end

  assign o_head     = mem_q[rd_q];
  assign o_count    = cnt_q;
  assign o_head_ptr = rd_q;
  assign o_full     = (cnt_q == TCS_COUNT_W'(DEPTH));
  assign o_empty    = (cnt_q == '0);

endmodule // tcs_dest_queue

// ---- verilog/tcs_channel_status.sv ----
// tcs_channel_status: programming slot, destination queue hand-off and the
// read-only channel status register behind an AXI4-Lite slave
// assumes the upstream channel controller, source engine and destination
// engine all run on i_sys_clk; their strobes are single-cycle pulses
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

module tcs_channel_status
  import tcs_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DEPTH  = TCS_DEST_QUEUE_DEPTH
)
(
  input  wire logic                i_sys_clk,      // 200 MHz system clock
  input  wire logic                i_nrst,         // async reset, active low
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,   // write address
  input  wire logic                s_axi_awvalid,  // write address valid
  output logic                     s_axi_awready,  // write address ready
  input  wire logic [31:0]         s_axi_wdata,    // write data
  input  wire logic [3:0]          s_axi_wstrb,    // write strobes
  input  wire logic                s_axi_wvalid,   // write data valid
  output logic                     s_axi_wready,   // write data ready
  output logic [1:0]               s_axi_bresp,    // write response
  output logic                     s_axi_bvalid,   // write response valid
  input  wire logic                s_axi_bready,   // write response ready
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,   // read address
  input  wire logic                s_axi_arvalid,  // read address valid
  output logic                     s_axi_arready,  // read address ready
  output logic [31:0]              s_axi_rdata,    // read data
  output logic [1:0]               s_axi_rresp,    // read response
  output logic                     s_axi_rvalid,   // read data valid
  input  wire logic                s_axi_rready,   // read data ready
  // upstream channel controller
  input  wire logic                i_load,         // load an order into the slot
  input  wire tcs_order_s          i_load_order,   // order loaded
  output logic                     o_program_slot_busy, // slot cannot take an order
  // source engine
  output logic                     o_src_start,    // pulse: new order for source side
  output tcs_order_s               o_src_order,    // source active order
  input  wire logic                i_src_done,     // pulse: source side finished
  // destination engine
  output tcs_order_s               o_dst_head,     // order at destination queue head
  output logic                     o_dst_valid,    // destination queue not empty
  input  wire logic                i_dst_done,     // pulse: head order completed
  // write command tracking
  input  wire logic                i_wr_issue,     // pulse: write command issued
  input  wire logic                i_wr_resp       // pulse: write status received
);

  // the status fields only serve a four-slot queue, and the register map
  // needs twelve to thirty-two address bits; refuse anything else at elaboration
  if (ADDR_W < 12 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("tcs_channel_status: ADDR_W must lie in 12..32");
  end
  if (DEPTH != TCS_DEST_QUEUE_DEPTH)
  begin : g_bad_depth
    $error("tcs_channel_status: DEPTH must equal TCS_DEST_QUEUE_DEPTH");
  end

  // status register address at the bus width; only word bits are compared
  localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(TCS_CHANNEL_STATUS_OFS);

  // programming slot
  logic                       slot_valid_q;
  tcs_order_s                 slot_order_q;
  // destination queue view
  tcs_order_s                 q_head;
  logic [TCS_COUNT_W-1:0]     q_count;
  logic [TCS_PTR_W-1:0]       q_head_ptr;
  logic                       q_full;
  logic                       q_empty;
  logic                       q_pop;
  // source side
  logic                       src_active_q;
  tcs_order_s                 src_order_q;
  logic                       src_start_q;
  // write tracking
  logic [TCS_WR_CNT_W-1:0]    wr_out_q;
  // hand-off decision
  logic                       move;
  // bus state
  logic                       aw_got_q;
  logic                       w_got_q;
  logic [ADDR_W-1:0]          awaddr_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [1:0]                 rresp_q;
  logic [31:0]                rdata_q;
  logic [31:0]                status_word;
  logic                       rd_hit;
  logic                       wr_hit;
  // handshake strobes, one per channel
  logic                       aw_hs;
  logic                       w_hs;
  logic                       b_hs;
  logic                       ar_hs;
  logic                       r_hs;
  // slot load and write pending views
  logic                       slot_take;
  logic                       wr_pending;

  // an order leaves the slot when the queue is empty, or when it has room and
  // the source side is idle; a full queue holds the order in the slot
  // the registered source flag is used, so a done pulse frees the hand-off
  // one cycle late; a cycle is traded for a short path
  always_comb
  begin
    move = 1'b0;
    if (slot_valid_q)
    begin
      if (q_empty)
        move = 1'b1;
      else if (!q_full)
        move = !src_active_q;
      else
        move = 1'b0;
    end
  end

  // only a non-empty queue can complete its head; a stray done pulse on an
  // empty queue is dropped so the count never wraps
  assign q_pop = i_dst_done && !q_empty;

  // destination queue: pushed from the slot, popped on head completion
  tcs_dest_queue #(
    .DEPTH        (DEPTH)
  ) u_dest_queue (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_push       (move),
    .i_push_order (slot_order_q),
    .i_pop        (q_pop),
    .o_head       (q_head),
    .o_count      (q_count),
    .o_head_ptr   (q_head_ptr),
    .o_full       (q_full),
    .o_empty      (q_empty)
  );

  // a load is taken only while the slot is free; a load against a busy slot
  // is dropped without notice, so the controller must watch busy first
  assign slot_take = i_load && !slot_valid_q;

  // programming slot: a load in the cycle the slot empties is refused, since
  // busy is still high in that cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      slot_valid_q <= 1'b0;
      slot_order_q <= '0;
    end
    else if (slot_take)
    begin
      slot_valid_q <= 1'b1;
      slot_order_q <= i_load_order;
    end
    else if (move)
      slot_valid_q <= 1'b0;
  end

  // busy comes straight from the slot flop, so the controller sees no glitch
  assign o_program_slot_busy = slot_valid_q;

  // source side activity: a moved order makes the source busy; the set wins
  // over a done pulse in the same cycle, since the new order has not started
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      src_active_q <= 1'b0;
    else if (move)
      src_active_q <= 1'b1;
    else if (i_src_done)
      src_active_q <= 1'b0;
  end

  // the last order handed to the source side stays visible after it idles
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      src_order_q <= '0;
    else if (move)
      src_order_q <= slot_order_q;
  end

  // one-cycle start strobe toward the source engine, the cycle after a move
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      src_start_q <= 1'b0;
    else
      src_start_q <= move;
  end

  // outstanding write commands; saturating so a stray response cannot wrap
  // limitation: beyond fifteen writes in flight the pending flag clears early
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      wr_out_q <= '0;
    else if (i_wr_issue && !i_wr_resp)
    begin
      if (wr_out_q != '1)
        wr_out_q <= wr_out_q + 1'b1;
    end
    else if (i_wr_resp && !i_wr_issue)
    begin
      if (wr_out_q != '0)
        wr_out_q <= wr_out_q - 1'b1;
    end
  end

  // views toward the source and destination engines
  assign o_src_start = src_start_q;
  assign o_src_order = src_order_q;
  assign o_dst_head  = q_head;
  assign o_dst_valid = !q_empty;

  // a non-zero outstanding write count keeps the pending flag up
  assign wr_pending = (wr_out_q != '0);

  // status word assembled from live state; reserved bits come from the fixed
  // pattern and bit eight is forced, so a read never depends on what was
  // written to the register
  always_comb
  begin
    status_word                                     = TCS_STATUS_RESERVED;
    status_word[TCS_HEAD_OFS_MSB:TCS_HEAD_OFS_LSB]  = q_head_ptr;
    status_word[TCS_ONE_BIT]                        = TCS_ONE_VALUE;
    status_word[TCS_COUNT_MSB:TCS_COUNT_LSB]        = q_count;
    status_word[TCS_WR_PEND_BIT]                    = wr_pending;
    status_word[TCS_SRC_ACTIVE_BIT]                 = src_active_q;
    status_word[TCS_PROG_BUSY_BIT]                  = slot_valid_q;
  end

  // address decode on whole words; the low two address bits pick a byte and
  // are ignored, as every register is one aligned word
  assign rd_hit = (s_axi_araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);
  assign wr_hit = (awaddr_q[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);

  // write path: address and data accepted in either order, one write at a time
  // readies fall while a channel is held or a response waits, so a second
  // write is held off until the response has been taken
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;

  // channel handshakes: each channel moves one item when valid meets ready
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign b_hs  = s_axi_bvalid && s_axi_bready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign r_hs  = s_axi_rvalid && s_axi_rready;

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
    end
    else if (aw_got_q && w_got_q)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs)
        w_got_q <= 1'b1;
    end
  end

  // write response; the status register keeps no written value at all, and
  // an unmapped address answers with an error so software notices a bad map
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= TCS_RESP_OKAY;
    end
    else if (aw_got_q && w_got_q)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? TCS_RESP_OKAY : TCS_RESP_SLVERR;
    end
    else if (b_hs)
      bvalid_q <= 1'b0;
  end

  // response channel straight from its flops
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // read path: one read in flight; data is a snapshot taken at the address edge
  // so rdata never changes while rvalid waits for rready; unmapped reads
  // return zero with an error
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= TCS_RESP_OKAY;
      rdata_q  <= '0;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? TCS_RESP_OKAY : TCS_RESP_SLVERR;
      rdata_q  <= rd_hit ? status_word : TCS_UNMAPPED_DATA;
    end
    else if (r_hs)
      rvalid_q <= 1'b0;
  end

  // read channel straight from its flops
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule // tcs_channel_status

// ---- dv/tcs_channel_status_assertions.sv ----
// tcs_channel_status_assertions: port checks for the channel status block
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module tcs_channel_status_assertions
  import tcs_pkg::*;
#(
  parameter int DEPTH = TCS_DEST_QUEUE_DEPTH
)
(
  input wire logic        i_sys_clk,           // clock
  input wire logic        i_nrst,              // reset
  input wire logic        s_axi_arvalid,       // ar valid
  input wire logic        s_axi_arready,       // ar ready
  input wire logic        s_axi_rvalid,        // r valid
  input wire logic        s_axi_rready,        // r ready
  input wire logic [31:0] s_axi_rdata,         // r data
  input wire logic [1:0]  s_axi_rresp,         // r resp
  input wire logic        i_load,              // load
  input wire logic        o_program_slot_busy, // slot busy
  input wire logic        o_src_start,         // source start
  input wire logic        o_dst_valid          // queue not empty
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // slot hand-off into the destination queue
  a_load_sets_busy: assert property (i_load && !o_program_slot_busy |=> o_program_slot_busy)
    else $error("slot not busy after load");
  a_empty_moves: assert property (o_program_slot_busy && !o_dst_valid |=> !o_program_slot_busy && o_dst_valid)
    else $error("order not moved into empty queue");
  a_move_starts: assert property ($fell(o_program_slot_busy) |-> o_src_start && o_dst_valid)
    else $error("move without source start");
  a_start_pulse: assert property (o_src_start |=> !o_src_start)
    else $error("source start longer than one cycle");
  // register read path
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_fixed_bits: assert property (s_axi_rvalid && s_axi_rresp == TCS_RESP_OKAY |->
    s_axi_rdata[8] && s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[10:9] == 2'h0 && !s_axi_rdata[7]
    && !s_axi_rdata[3])
    else $error("fixed status bits wrong");
  a_count_range: assert property (s_axi_rvalid && s_axi_rresp == TCS_RESP_OKAY |-> s_axi_rdata[6:4] <= DEPTH)
    else $error("queue count out of range");
  cover property ($fell(o_program_slot_busy));
  cover property (o_program_slot_busy && o_dst_valid);
  cover property (s_axi_rvalid && s_axi_rdata[6:4] == 3'h4);
endmodule // tcs_channel_status_assertions

bind tcs_channel_status tcs_channel_status_assertions #(.DEPTH(DEPTH)) chk_i (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .i_load(i_load), .o_program_slot_busy(o_program_slot_busy),
  .o_src_start(o_src_start), .o_dst_valid(o_dst_valid));

// ---- dv/tcs_upstream_model.sv ----
// tcs_upstream_model: stand-in for the upstream channel controller
// assumes the slot busy flag is a registered level on i_sys_clk
`timescale 1ns/1ps
module tcs_upstream_model
  import tcs_pkg::*;
(
  input  wire logic i_sys_clk, // clock
  input  wire logic i_nrst,    // reset
  input  wire logic i_go,      // loading allowed
  input  wire logic i_slow,    // random gaps
  input  wire logic i_busy,    // slot busy
  output logic       o_load,   // load strobe
  output tcs_order_s o_order   // order offered
);
  logic [1:0] gap_q;
  logic [7:0] tag_q;
  // idle data lines toggle so a stale order never looks valid
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_load <= 1'b0;
      o_order <= '0;
      gap_q <= 2'h0;
      tag_q <= 8'h00;
    end
    else
    begin
      o_load <= 1'b0;
      o_order <= ~o_order;
      if (gap_q != 2'h0)
        gap_q <= gap_q - 2'h1;
      else if (i_go && !i_busy && !o_load)
      begin
        o_load <= 1'b1;
        o_order <= '{tag: tag_q, word: $urandom};
        tag_q <= tag_q + 8'h01;
        gap_q <= i_slow ? 2'($urandom_range(3)) : 2'h0;
      end
    end
  end
endmodule // tcs_upstream_model

// ---- dv/tcs_channel_status_tb.sv ----
// tcs_channel_status_tb: self-checking bench with a queue model
// assumes reads are made only while order traffic is quiet
`timescale 1ns/1ps
module tcs_channel_status_tb import tcs_pkg::*;;
  logic        clk, nrst, go, slow, rnd, load, busy, dvalid, sstart;
  logic        src_done, dst_done, wr_issue, wr_resp;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp;
  tcs_order_s  order, sorder, dhead, m_slot, m_srco;
  tcs_order_s  m_q[$];
  int          m_cnt, m_head, m_pend, p_dst, bad_count, tests_run;
  bit          m_src, m_busy, mv, pop, m_start;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  tcs_channel_status tcs_channel_status_i (.i_sys_clk(clk), .i_nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .i_load(load), .i_load_order(order), .o_program_slot_busy(busy),
    .o_src_start(sstart), .o_src_order(sorder), .i_src_done(src_done), .o_dst_head(dhead), .o_dst_valid(dvalid),
    .i_dst_done(dst_done), .i_wr_issue(wr_issue), .i_wr_resp(wr_resp));

  tcs_upstream_model tcs_upstream_model_i (.i_sys_clk(clk), .i_nrst(nrst), .i_go(go), .i_slow(slow),
    .i_busy(busy), .o_load(load), .o_order(order));

  // reference model; its random source done and write response pulses only finish what is really under way, dst_done may hit an empty queue
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      {m_cnt, m_head, m_pend, m_src, m_busy, m_start, m_slot, m_srco} = '0;
      m_q.delete();
      {src_done, dst_done, wr_issue, wr_resp} <= '0;
    end
    else
    begin
      mv = m_busy && (m_cnt == 0 || (m_cnt < 4 && !m_src));
      pop = dst_done && m_cnt > 0;
      m_head = pop ? (m_head + 1) % 4 : m_head;
      m_cnt = m_cnt + mv - pop;
      if (pop)
        void'(m_q.pop_front());
      if (mv)
      begin
        m_q.push_back(m_slot);
        m_srco = m_slot;
      end
      if (load && !m_busy)
        m_slot = order;
      m_start = mv;
      m_src = mv ? 1'b1 : (src_done ? 1'b0 : m_src);
      m_busy = mv ? 1'b0 : (load ? 1'b1 : m_busy);
      m_pend = m_pend + wr_issue - wr_resp;
      r = $urandom;
      src_done <= rnd && m_src && r[1:0] == 2'h0;
      dst_done <= rnd && int'(r[5:3]) < p_dst;
      wr_issue <= rnd && r[6] && m_pend < 8;
      wr_resp <= rnd && !r[6] && r[7] && m_pend > 0;
    end

  function automatic logic [31:0] st();
    return (32'(m_head) << 11) | 32'h100 | (32'(m_cnt) << 4) | {29'h0, m_pend != 0, m_src, m_busy};
  endfunction

  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ord(input string nm, input tcs_order_s e, input tcs_order_s g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic seen(input int k);
    case (k)
      0: return arready;
      1: return rvalid;
      2: return awready && wready;
      default: return bvalid;
    endcase
  endfunction

  // bounded wait on a bus answer, sampled at the settled falling edge
  task automatic w4(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (seen(k) !== 1'b1 && n < 200);
    if (seen(k) !== 1'b1)
    begin
      bad_count++;
      end_sim;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    w4(0);
    @(posedge clk);
    arvalid <= 1'b0;
    // a late rready keeps the answer waiting, so it must stand meanwhile
    repeat ($urandom_range(2)) @(posedge clk);
    rready <= 1'b1;
    w4(1);
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    w4(2);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    w4(3);
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge clk);
    bready <= 1'b0;
  endtask

  // slot and queue flags checked every cycle
  always @(negedge clk)
    if (nrst)
    begin
      chk("slot_busy", 32'(m_busy), 32'(busy));
      chk("dst_valid", 32'(m_cnt != 0), 32'(dvalid));
      chk("src_start", 32'(m_start), 32'(sstart));
      chk_ord("src_order", m_srco, sorder);
      if (m_q.size() > 0)
        chk_ord("dst_head", m_q[0], dhead);
    end

  initial
  begin
    {go, slow, rnd, awvalid, wvalid, arvalid, bready, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {nrst, bad_count, tests_run, p_dst} = '0;
    void'($urandom(32'h229557DE));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(TCS_CHANNEL_STATUS_OFS, 32'h100, TCS_RESP_OKAY);
    wr(TCS_CHANNEL_STATUS_OFS, 32'hFFFF_FFFF, TCS_RESP_OKAY);
    rd(TCS_CHANNEL_STATUS_OFS, 32'h100, TCS_RESP_OKAY);
    wr(12'h004, 32'h1, TCS_RESP_SLVERR);
    rd(12'h004, 32'h0, TCS_RESP_SLVERR);
    // first burst never pops, so the queue fills up and the slot must wait
    for (int i = 0; i < 30; i++)
    begin
      p_dst = (i == 0) ? 0 : int'($urandom_range(4));
      slow <= i[0];
      go <= 1'b1;
      rnd <= 1'b1;
      repeat (40) @(posedge clk);
      go <= 1'b0;
      rnd <= 1'b0;
      repeat (5) @(posedge clk);
      rd(TCS_CHANNEL_STATUS_OFS, st(), TCS_RESP_OKAY);
    end
    end_sim;
  end
endmodule // tcs_channel_status_tb
